// File: src/tester_pkg.sv
// constants of the receive-side pattern tester counters and interrupts
// assumes a 32-bit Avalon-MM slave with one register per aligned word
package tester_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] STATUS_IDX = 8'h6C;
    localparam logic [7:0] LATCHED_IDX = 8'h6E;
    localparam logic [7:0] IRQ_EN_IDX = 8'h70;
    localparam logic [7:0] ERR_LOW_IDX = 8'h74;
    localparam logic [7:0] ERR_HIGH_IDX = 8'h76;
    localparam logic [7:0] BIT_LOW_IDX = 8'h78;
    localparam logic [7:0] BIT_HIGH_IDX = 8'h7A;
    localparam logic [7:0] PORT_GATE_IDX = 8'h7C;

    // field positions shared by latched and enable registers; status has no error bit, the port gate bit is its own
    localparam int UPDATE_POS = 3;
    localparam int ERROR_POS = 2;
    localparam int NONZERO_POS = 1;
    localparam int SYNC_POS = 0;
    localparam int PORT_GATE_POS = 0;

    // widths
    localparam int ERR_TALLY_W = 24;
    localparam int BIT_TALLY_W = 32;
    localparam int EVENT_W = 4;
    localparam int ADDR_W = 10;

    // reset values
    localparam logic [3:0] IRQ_EN_RESET = 4'h0;
    localparam logic [3:0] LATCHED_RESET = 4'h0;
    localparam logic [23:0] ERR_TALLY_RESET = 24'h00_0000;
    localparam logic [31:0] BIT_TALLY_RESET = 32'h0000_0000;
    localparam logic [31:0] READ_RESET = 32'h0000_0000;

    // saturation limits
    localparam logic [23:0] ERR_TALLY_MAX = 24'hFF_FFFF;
    localparam logic [31:0] BIT_TALLY_MAX = 32'hFFFF_FFFF;

endpackage

// File: src/pattern_tester_rx_counters_irq.sv
// receive bit and bit-error tallies, update snapshots and tester interrupt
// assumes detector inputs come from logic on CORE_CLK_IN; one per port
`timescale 1ns/100ps
`default_nettype none

module pattern_tester_rx_counters_irq (
    input wire logic CORE_CLK_IN,
    input wire logic RESET_IN,
    input wire logic [tester_pkg::ADDR_W-1:0] ADDRESS_IN,
    input wire logic READ_IN,
    input wire logic WRITE_IN,
    input wire logic [31:0] WRITEDATA_IN,
    input wire logic [3:0] BYTEENABLE_IN,
    output logic [31:0] READDATA_OUT,
    output logic WAITREQUEST_OUT,
    input wire logic RX_BIT_VALID_IN,
    input wire logic RX_BIT_ERROR_IN,
    input wire logic PATTERN_UNLOCKED_IN,
    input wire logic COUNTER_UPDATE_STROBE_IN,
    output logic IRQ_OUT
);

    typedef struct packed {
        logic wait_req;
        logic [31:0] rd_data;
        logic irq;
        logic [3:0] irq_en;
        logic port_gate;
        logic [3:0] latched;
        logic update_done_status;
        logic pattern_unlocked;
        logic nonzero_q;
        logic upd_q;
        logic [23:0] error_tally;
        logic [31:0] received_bit_tally;
        logic [23:0] error_snap;
        logic [31:0] bit_snap;
    } state_s;

    state_s st;
    state_s next_st;

    logic [7:0] word_idx;
    logic bus_req;
    logic write_now;
    logic upd_rise;
    logic count_bit;
    logic count_err;
    logic error_count_nonzero;
    logic [3:0] event_set;
    logic [3:0] armed;

    assign word_idx = ADDRESS_IN[9:2];
    assign bus_req = READ_IN | WRITE_IN;
    assign write_now = WRITE_IN & ~st.wait_req;
    // update acts on the strobe's rising edge only; a held level is one update
    assign upd_rise = COUNTER_UPDATE_STROBE_IN & ~st.upd_q;
    assign count_bit = RX_BIT_VALID_IN & ~st.pattern_unlocked;
    assign count_err = count_bit & RX_BIT_ERROR_IN;
    assign error_count_nonzero = (st.error_tally != tester_pkg::ERR_TALLY_RESET);

    always_comb begin
        event_set = '0;
        event_set[tester_pkg::UPDATE_POS] =
            next_st.update_done_status & ~st.update_done_status;
        event_set[tester_pkg::ERROR_POS] =
            RX_BIT_VALID_IN & RX_BIT_ERROR_IN;
        event_set[tester_pkg::NONZERO_POS] =
            error_count_nonzero & ~st.nonzero_q;
        event_set[tester_pkg::SYNC_POS] =
            PATTERN_UNLOCKED_IN ^ st.pattern_unlocked;
    end

    // update-done is not gated by the port gate; the others are
    always_comb begin
        armed = st.latched & st.irq_en;
        armed[tester_pkg::ERROR_POS] =
            armed[tester_pkg::ERROR_POS] & st.port_gate;
        armed[tester_pkg::NONZERO_POS] =
            armed[tester_pkg::NONZERO_POS] & st.port_gate;
        armed[tester_pkg::SYNC_POS] =
            armed[tester_pkg::SYNC_POS] & st.port_gate;
    end

    function automatic logic [31:0] read_mux(input state_s s,
                                             input logic [7:0] idx,
                                             input logic nz);
        logic [31:0] w;
        w = tester_pkg::READ_RESET;
        case (idx)
            tester_pkg::STATUS_IDX: begin
                w[tester_pkg::UPDATE_POS] = s.update_done_status;
                w[tester_pkg::NONZERO_POS] = nz;
                w[tester_pkg::SYNC_POS] = s.pattern_unlocked;
            end
            tester_pkg::LATCHED_IDX: begin
                w[3:0] = s.latched;
            end
            tester_pkg::IRQ_EN_IDX: begin
                w[3:0] = s.irq_en;
            end
            tester_pkg::ERR_LOW_IDX: begin
                w[15:0] = s.error_snap[15:0];
            end
            tester_pkg::ERR_HIGH_IDX: begin
                w[7:0] = s.error_snap[23:16];
            end
            tester_pkg::BIT_LOW_IDX: begin
                w[15:0] = s.bit_snap[15:0];
            end
            tester_pkg::BIT_HIGH_IDX: begin
                w[15:0] = s.bit_snap[31:16];
            end
            tester_pkg::PORT_GATE_IDX: begin
                w[tester_pkg::PORT_GATE_POS] = s.port_gate;
            end
            default: begin
                w = tester_pkg::READ_RESET;
            end
        endcase
        return w;
    endfunction

    always_comb begin
        next_st = st;
        next_st.upd_q = COUNTER_UPDATE_STROBE_IN;
        next_st.pattern_unlocked = PATTERN_UNLOCKED_IN;
        next_st.nonzero_q = error_count_nonzero;
        // status rises the cycle after the snapshot, drops with the strobe
        next_st.update_done_status = COUNTER_UPDATE_STROBE_IN & st.upd_q;

        // live tallies: saturate, freeze while unlocked, restart on update
        if (upd_rise) begin
            next_st.error_snap = st.error_tally;
            next_st.bit_snap = st.received_bit_tally;
            next_st.error_tally = {23'h00_0000, count_err};
            next_st.received_bit_tally = {31'h0000_0000, count_bit};
        end else begin
            if (count_err && st.error_tally != tester_pkg::ERR_TALLY_MAX) begin
                next_st.error_tally = st.error_tally + 24'h00_0001;
            end
            if (count_bit &&
                st.received_bit_tally != tester_pkg::BIT_TALLY_MAX) begin
                next_st.received_bit_tally =
                    st.received_bit_tally + 32'h0000_0001;
            end
        end

        // one wait state: data loaded on the first cycle, taken on the second
        if (bus_req && st.wait_req) begin
            next_st.wait_req = 1'b0;
            next_st.rd_data = read_mux(st, word_idx, error_count_nonzero);
        end else begin
            next_st.wait_req = 1'b1;
        end

        next_st.latched = st.latched;
        if (write_now && BYTEENABLE_IN[0]) begin
            case (word_idx)
                tester_pkg::IRQ_EN_IDX: begin
                    next_st.irq_en = WRITEDATA_IN[3:0];
                end
                tester_pkg::LATCHED_IDX: begin
                    next_st.latched = st.latched & ~WRITEDATA_IN[3:0];
                end
                tester_pkg::PORT_GATE_IDX: begin
                    next_st.port_gate = WRITEDATA_IN[tester_pkg::PORT_GATE_POS];
                end
                default: begin
                    next_st.irq_en = st.irq_en;
                end
            endcase
        end
        // a new event beats a clearing write in the same cycle
        next_st.latched = next_st.latched | event_set;

        next_st.irq = |armed;
    end

    // one instance per port; the port prefix decode sits in the fabric
    always_ff @(posedge CORE_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            st.wait_req <= 1'b1;
            st.rd_data <= tester_pkg::READ_RESET;
            st.irq <= 1'b0;
            st.irq_en <= tester_pkg::IRQ_EN_RESET;
            st.port_gate <= 1'b0;
            st.latched <= tester_pkg::LATCHED_RESET;
            st.update_done_status <= 1'b0;
            st.pattern_unlocked <= 1'b0;
            st.nonzero_q <= 1'b0;
            st.upd_q <= 1'b0;
            st.error_tally <= tester_pkg::ERR_TALLY_RESET;
            st.received_bit_tally <= tester_pkg::BIT_TALLY_RESET;
            st.error_snap <= tester_pkg::ERR_TALLY_RESET;
            st.bit_snap <= tester_pkg::BIT_TALLY_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign READDATA_OUT = st.rd_data;
    assign WAITREQUEST_OUT = st.wait_req;
    assign IRQ_OUT = st.irq;

    default clocking @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (RESET_IN);

    sequence upd_edge_s;
        upd_rise;
    endsequence

    sequence upd_done_s;
        st.update_done_status && !$past(st.update_done_status);
    endsequence

    sequence rd_req_s(logic [7:0] idx);
        READ_IN && st.wait_req && word_idx == idx;
    endsequence

    update_irq_a: assert property (
        st.latched[3] && st.irq_en[3] |=> IRQ_OUT)
        else $error("update-done interrupt not raised");
    error_irq_a: assert property (
        st.latched[2] && st.irq_en[2] && st.port_gate |=> IRQ_OUT)
        else $error("bit-error interrupt not raised");
    nonzero_irq_a: assert property (
        st.latched[1] && st.irq_en[1] && st.port_gate |=> IRQ_OUT)
        else $error("nonzero-count interrupt not raised");
    sync_irq_a: assert property (
        st.latched[0] && st.irq_en[0] && st.port_gate |=> IRQ_OUT)
        else $error("sync-change interrupt not raised");
    irq_quiet_a: assert property (
        (st.latched & st.irq_en) == 4'h0 |=> !IRQ_OUT)
        else $error("interrupt raised with nothing enabled");
    gate_block_a: assert property (
        !st.port_gate && !(st.latched[3] && st.irq_en[3]) |=> !IRQ_OUT)
        else $error("gated interrupt leaked");
    err_high_read_a: assert property (
        rd_req_s(tester_pkg::ERR_HIGH_IDX) |=>
            !WAITREQUEST_OUT &&
            READDATA_OUT == {24'h00_0000, $past(st.error_snap[23:16])})
        else $error("error tally high half read wrong");
    bit_high_read_a: assert property (
        rd_req_s(tester_pkg::BIT_HIGH_IDX) |=>
            !WAITREQUEST_OUT &&
            READDATA_OUT == {16'h0000, $past(st.bit_snap[31:16])})
        else $error("bit tally high half read wrong");
    err_saturate_a: assert property (
        st.error_tally == tester_pkg::ERR_TALLY_MAX && !upd_rise |=>
            st.error_tally == tester_pkg::ERR_TALLY_MAX)
        else $error("error tally wrapped");
    err_frozen_a: assert property (
        st.pattern_unlocked && !upd_rise |=> $stable(st.error_tally))
        else $error("error tally moved while unlocked");
    bit_saturate_a: assert property (
        st.received_bit_tally == tester_pkg::BIT_TALLY_MAX && !upd_rise |=>
            st.received_bit_tally == tester_pkg::BIT_TALLY_MAX)
        else $error("bit tally wrapped");
    bit_frozen_a: assert property (
        st.pattern_unlocked && !upd_rise |=> $stable(st.received_bit_tally))
        else $error("bit tally moved while unlocked");
    snap_hold_a: assert property (
        !upd_rise |=> $stable(st.bit_snap) && $stable(st.error_snap))
        else $error("snapshot changed without update");
    snap_take_a: assert property (
        upd_edge_s |=> st.bit_snap == $past(st.received_bit_tally))
        else $error("snapshot not taken on update");
    unlock_status_a: assert property (
        1'b1 |=> st.pattern_unlocked == $past(PATTERN_UNLOCKED_IN))
        else $error("unlocked status does not follow detector");
    error_latch_a: assert property (
        RX_BIT_VALID_IN && RX_BIT_ERROR_IN |=> st.latched[2])
        else $error("bit error not latched");
    sync_latch_a: assert property (
        PATTERN_UNLOCKED_IN != st.pattern_unlocked |=> st.latched[0])
        else $error("sync change not latched");
    update_seq_a: assert property (
        upd_edge_s ##1 COUNTER_UPDATE_STROBE_IN |=> upd_done_s ##0 st.latched[3])
        else $error("update-done not latched after update");
    wait_once_a: assert property (
        bus_req && st.wait_req |=> !WAITREQUEST_OUT ##1 WAITREQUEST_OUT)
        else $error("bus answer not one wait state");
    err_low_read_a: assert property (
        rd_req_s(tester_pkg::ERR_LOW_IDX) |=>
            READDATA_OUT == {16'h0000, $past(st.error_snap[15:0])})
        else $error("error tally low half read wrong");
    bit_low_read_a: assert property (
        rd_req_s(tester_pkg::BIT_LOW_IDX) |=>
            READDATA_OUT == {16'h0000, $past(st.bit_snap[15:0])})
        else $error("bit tally low half read wrong");
    status_read_a: assert property (
        rd_req_s(tester_pkg::STATUS_IDX) |=>
            READDATA_OUT[tester_pkg::SYNC_POS] == $past(st.pattern_unlocked))
        else $error("unlocked status read wrong");
    en_write_a: assert property (
        write_now && BYTEENABLE_IN[0] &&
            word_idx == tester_pkg::IRQ_EN_IDX |=>
            st.irq_en == $past(WRITEDATA_IN[3:0]))
        else $error("interrupt enable write lost");
    en_hold_a: assert property (
        !(write_now && word_idx == tester_pkg::IRQ_EN_IDX) |=>
            $stable(st.irq_en))
        else $error("interrupt enable changed without write");
    err_count_a: assert property (
        count_err && !upd_rise &&
            st.error_tally != tester_pkg::ERR_TALLY_MAX |=>
            st.error_tally == $past(st.error_tally) + 24'h00_0001)
        else $error("error tally missed a counted error");
    bit_count_a: assert property (
        count_bit && !upd_rise &&
            st.received_bit_tally != tester_pkg::BIT_TALLY_MAX |=>
            st.received_bit_tally ==
                $past(st.received_bit_tally) + 32'h0000_0001)
        else $error("bit tally missed a counted bit");
    nonzero_latch_a: assert property (
        error_count_nonzero && !st.nonzero_q |=> st.latched[1])
        else $error("nonzero-count flag not latched");
    nonzero_clear_a: assert property (
        upd_rise && !count_err |=> !error_count_nonzero)
        else $error("error tally not restarted on update");
    flags_sticky_a: assert property (
        !(write_now && word_idx == tester_pkg::LATCHED_IDX) |=>
            (st.latched & $past(st.latched)) == $past(st.latched))
        else $error("latched flag dropped without a clear");
    update_drop_a: assert property (
        !COUNTER_UPDATE_STROBE_IN |=> !st.update_done_status)
        else $error("update status stays up without strobe");

endmodule

`default_nettype wire

// File: testbench/test_pattern_tester_rx_counters_irq.sv
// self-checking bench for the receive tester tallies and interrupt
// assumes one port instance; every bus answer comes within the timeout
`timescale 1ns/100ps
`default_nettype none

module test_pattern_tester_rx_counters_irq;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [tester_pkg::ADDR_W-1:0] addr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] be = 4'hF;
    logic [31:0] rdata;
    logic waitreq;
    logic bit_valid = 1'b0;
    logic bit_err = 1'b0;
    logic unlocked = 1'b0;
    logic strobe = 1'b0;
    logic irq;
    int errors = 0;
    int n_checks = 0;
    logic [23:0] exp_err = 24'h00_0000;
    logic [31:0] exp_bits = 32'h0000_0000;
    logic [31:0] old_bits;
    logic [31:0] val;
    logic [7:0] regs [9] = '{tester_pkg::STATUS_IDX, tester_pkg::LATCHED_IDX,
        tester_pkg::IRQ_EN_IDX, tester_pkg::ERR_LOW_IDX,
        tester_pkg::ERR_HIGH_IDX, tester_pkg::BIT_LOW_IDX,
        tester_pkg::BIT_HIGH_IDX, tester_pkg::PORT_GATE_IDX, 8'h20};

    pattern_tester_rx_counters_irq dut (
        .CORE_CLK_IN(clk), .RESET_IN(rst), .ADDRESS_IN(addr),
        .READ_IN(rd), .WRITE_IN(wr), .WRITEDATA_IN(wdata),
        .BYTEENABLE_IN(be), .READDATA_OUT(rdata),
        .WAITREQUEST_OUT(waitreq), .RX_BIT_VALID_IN(bit_valid),
        .RX_BIT_ERROR_IN(bit_err), .PATTERN_UNLOCKED_IN(unlocked),
        .COUNTER_UPDATE_STROBE_IN(strobe), .IRQ_OUT(irq)
    );

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    // request held until waitrequest is seen low, released after that edge
    task automatic bus(input logic is_wr, input logic [7:0] idx,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        addr <= {idx, 2'b00};
        rd <= ~is_wr;
        wr <= is_wr;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        if (waitreq !== 1'b0) begin
            errors++;
            $display("unexpected at %0t: no bus answer", $time);
            conclude();
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wr_reg(input logic [7:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d, val);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] want);
        bus(1'b0, idx, 32'h0000_0000, val);
        check(val, want);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // random bits, then one sure error so the error flag always fires
    task automatic send(input int n, input logic counted);
        logic v;
        logic e;
        for (int i = 0; i <= n; i++) begin
            v = (i == n) ? 1'b1 : 1'($urandom);
            e = (i == n) ? 1'b1 : 1'($urandom);
            @(posedge clk);
            bit_valid <= v;
            bit_err <= e;
            if (counted && v) begin
                exp_bits++;
                if (e) exp_err++;
            end
        end
        @(posedge clk);
        bit_valid <= 1'b0;
        bit_err <= 1'b0;
    endtask

    function automatic logic [31:0] irq_want(input int i, input logic g);
        return {31'h0, (i == tester_pkg::UPDATE_POS) || g};
    endfunction

    task automatic update;
        @(posedge clk);
        strobe <= 1'b1;
        idle(3);
    endtask

    initial begin
        void'($urandom(32'h7195b403));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        foreach (regs[i]) rd_chk(regs[i], 32'h0000_0000);
        wr_reg(tester_pkg::ERR_LOW_IDX, 32'hFFFF_FFFF);
        wr_reg(8'h20, 32'hFFFF_FFFF);
        rd_chk(tester_pkg::ERR_LOW_IDX, 32'h0000_0000);
        rd_chk(8'h20, 32'h0000_0000);
        // a write without the low byte lane must leave the enables alone
        be <= 4'hE;
        wr_reg(tester_pkg::IRQ_EN_IDX, 32'h0000_000F);
        be <= 4'hF;
        rd_chk(tester_pkg::IRQ_EN_IDX, 32'h0000_0000);
        wr_reg(tester_pkg::IRQ_EN_IDX, 32'h0000_000F);
        rd_chk(tester_pkg::IRQ_EN_IDX, 32'h0000_000F);
        wr_reg(tester_pkg::IRQ_EN_IDX, 32'h0000_0000);
        // tallies must stay frozen while the detector is unlocked
        @(posedge clk);
        unlocked <= 1'b1;
        idle(2);
        send(30, 1'b0);
        rd_chk(tester_pkg::STATUS_IDX, 32'h0000_0001);
        @(posedge clk);
        unlocked <= 1'b0;
        idle(2);
        send(200, 1'b1);
        idle(2);
        rd_chk(tester_pkg::ERR_LOW_IDX, 32'h0000_0000);
        rd_chk(tester_pkg::STATUS_IDX, 32'h0000_0002);
        update();
        rd_chk(tester_pkg::STATUS_IDX, 32'h0000_0008);
        rd_chk(tester_pkg::ERR_LOW_IDX, {16'h0, exp_err[15:0]});
        rd_chk(tester_pkg::ERR_HIGH_IDX, {24'h0, exp_err[23:16]});
        rd_chk(tester_pkg::BIT_LOW_IDX, {16'h0, exp_bits[15:0]});
        rd_chk(tester_pkg::BIT_HIGH_IDX, {16'h0, exp_bits[31:16]});
        old_bits = exp_bits;
        exp_bits = 32'h0000_0000;
        exp_err = 24'h00_0000;
        @(posedge clk);
        strobe <= 1'b0;
        idle(2);
        rd_chk(tester_pkg::LATCHED_IDX, 32'h0000_000F);
        check({31'h0, irq}, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            for (int g = 0; g < 2; g++) begin
                wr_reg(tester_pkg::PORT_GATE_IDX, 32'(g));
                wr_reg(tester_pkg::IRQ_EN_IDX, 32'h0000_0001 << i);
                idle(2);
                check({31'h0, irq}, irq_want(i, 1'(g)));
            end
        end
        wr_reg(tester_pkg::IRQ_EN_IDX, 32'h0000_0000);
        idle(2);
        check({31'h0, irq}, 32'h0000_0000);
        wr_reg(tester_pkg::IRQ_EN_IDX, 32'h0000_000F);
        wr_reg(tester_pkg::LATCHED_IDX, 32'h0000_000F);
        rd_chk(tester_pkg::LATCHED_IDX, 32'h0000_0000);
        idle(2);
        check({31'h0, irq}, 32'h0000_0000);
        // second period: old snapshot stands until the next strobe
        send(50, 1'b1);
        rd_chk(tester_pkg::BIT_LOW_IDX, {16'h0, old_bits[15:0]});
        update();
        rd_chk(tester_pkg::BIT_LOW_IDX, {16'h0, exp_bits[15:0]});
        rd_chk(tester_pkg::ERR_LOW_IDX, {16'h0, exp_err[15:0]});
        @(posedge clk);
        strobe <= 1'b0;
        idle(2);
        conclude();
    end
endmodule

`default_nettype wire
